// ### include/addr_decoder_defines.svh
// Purpose: constants for the system address decoder and remap block
// Assumes: 32-bit byte addresses from the processor core
// Notes:   offsets, fields, reset values and timing counts only
`ifndef ADDR_DECODER_DEFINES_SVH
`define ADDR_DECODER_DEFINES_SVH

`define INT_REGION_TOP      32'h0040_0000
`define PERIPH_REGION_BASE  32'hffc0_0000
`define PRIMARY_SRAM_BYTES  32'h0000_2000
`define EXT_SRAM_BASE       32'h0010_0000
`define EXT_SRAM_BYTES      32'h0002_0000
`define VECTOR_TOP          32'h0000_0020
`define INTC_WINDOW_BASE    32'hffff_f000
`define PERIPH_WIN_SHIFT    14
`define INTC_WIN_SHIFT      12
`define BOOT_SAMPLE_CYCLES  10
`define FIRST_FETCH_CYCLES  80
`define BOOT_SEL_RESET      1'b0
`define EXT_BANK_SHIFT_MIN  20
`define EXT_BANK_SHIFT_MAX  24

`endif

// ### include/addr_decoder_pkg.sv
// Purpose: types shared by the address decoder and its bench
// Assumes: nothing beyond the defines header
// Notes:   access descriptors and region codes
package addr_decoder_pkg;

	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_HALF,
		SIZE_WORD
	} acc_size_e;

	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_PRIMARY_SRAM,
		TGT_EXT_SRAM,
		TGT_EXT_BUS,
		TGT_PERIPH
	} target_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fetch;
		acc_size_e   size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cpu_req_s;

	typedef struct packed {
		logic [3:0] wait_states;
		logic [2:0] float_cycles;
		logic       width16;
	} bank_cfg_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		acc_size_e   size;
		logic [2:0]  chip_sel;
		logic [3:0]  wait_states;
		logic [2:0]  float_cycles;
		logic        width16;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ext_req_s;

endpackage : addr_decoder_pkg

// ### rtl/system_address_decoder_remap.sv
// Purpose: decode core addresses into internal SRAM, external bus and peripheral regions
// Assumes: one request per clock; internal SRAM answers on the cycle after the access
// Notes:   boot memory picked by a strap at reset release; remap is one-way
`timescale 1ns/1ns
`include "addr_decoder_defines.svh"

module system_address_decoder_remap
	import addr_decoder_pkg::*;
#(
	parameter int NUM_BANKS  = 8,  // external banks (4 or 8)
	parameter int BANK_SHIFT = 20  // log2 of bank size, 20..24
) (
	input  wire logic                 clk,                // master clock
	input  wire logic                 rst,                // external reset, high
	input  wire logic                 wdog_reset,         // internal watchdog reset, high
	input  wire logic                 boot_select_pin,    // boot strap input
	input  wire cpu_req_s             cpu_req,            // core access request
	output logic [31:0]               cpu_rdata,          // core read data
	output logic                      cpu_ready,          // access done this cycle
	output logic                      cpu_abort,          // data or prefetch abort
	output logic                      fetch_enable,       // core may fetch
	input  wire logic                 remap_command_bit,  // remap control register write of one
	input  wire bank_cfg_s [7:0]      bank_cfg,           // per-chip-select settings
	input  wire logic [7:0]           bank_defined,       // bank enabled in config
	output ext_req_s                  ext_req,            // request to external bus unit
	input  wire logic                 ext_done,           // external access finished
	input  wire logic [31:0]          ext_rdata,          // external read data
	output logic                      periph_sel,         // peripheral bus select
	output logic                      periph_write,       // peripheral write
	output logic [31:0]               periph_addr,        // word-aligned peripheral address
	output logic [31:0]               periph_wdata,       // peripheral write data
	output logic [7:0]                periph_index,       // 16 KB window number
	output logic                      intc_sel,           // interrupt controller window hit
	input  wire logic [31:0]          periph_rdata,       // peripheral read data
	output logic                      boot_from_ext_sram, // sampled boot mode
	output logic                      remapped,           // remap in force
	output logic                      ext_sram_wr_detect, // write hit extended SRAM
	output logic                      strap_free          // strap pin free for I/O
);

	localparam int PRI_WORDS = `PRIMARY_SRAM_BYTES / 4;
	localparam int EXT_WORDS = `EXT_SRAM_BYTES / 4;

	logic [31:0] pri_mem [PRI_WORDS];
	logic [31:0] ext_mem [EXT_WORDS];

	logic        strap_ok_ff;
	logic        strap_last_ff;
	logic        boot_sel_ff;
	logic        remap_ff;
	logic [6:0]  fetch_cnt_ff;
	logic        fetch_en_ff;
	logic        wr_detect_ff;
	logic [31:0] rdata_ff;
	logic        ext_busy_ff;
	ext_req_s    ext_req_ff;
	logic        abort_ff;

	target_e     target;
	logic [31:0] local_addr;
	logic [2:0]  cs_num;
	logic        ext_legal;

	// byte-lane write enables, little-endian only
	function automatic logic [3:0] lane_mask(input acc_size_e sz, input logic [1:0] a);
		case (sz)
			SIZE_BYTE: lane_mask = 4'h1 << a;
			SIZE_HALF: lane_mask = a[1] ? 4'hc : 4'h3;
			default:   lane_mask = 4'hf;
		endcase
	endfunction : lane_mask

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] m);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (m[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// strap sampled on every edge while reset is held; the last sample before release
	// wins, so the pin must stay steady over the final cycles; watchdog leaves it alone
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_last_ff <= boot_select_pin;
		end
	end

	// boot mode latched on the first edge after reset release
	always_ff @(posedge clk) begin
		strap_ok_ff <= rst;
		if (strap_ok_ff && !rst) begin
			boot_sel_ff <= strap_last_ff;
		end
	end

	// remap: set by command, cleared only by a reset of either kind
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remap_ff <= 1'b0;
		end else if (wdog_reset) begin
			remap_ff <= 1'b0;
		end else if (remap_command_bit) begin
			remap_ff <= 1'b1;
		end
	end

	// fetch release counter after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_cnt_ff <= 7'h00;
			fetch_en_ff  <= 1'b0;
		end else if (wdog_reset) begin
			fetch_cnt_ff <= 7'h00;
			fetch_en_ff  <= 1'b0;
		end else if (!fetch_en_ff) begin
			fetch_cnt_ff <= fetch_cnt_ff + 7'h01;
			if (fetch_cnt_ff == 7'(`FIRST_FETCH_CYCLES - 1)) begin
				fetch_en_ff <= 1'b1;
			end
		end
	end

	// region decode
	always_comb begin
		target     = TGT_NONE;
		local_addr = cpu_req.addr;
		cs_num     = 3'h0;
		ext_legal  = 1'b0;
		if (cpu_req.addr >= `PERIPH_REGION_BASE) begin
			target = TGT_PERIPH;
		end else if (cpu_req.addr >= `INT_REGION_TOP) begin
			target    = TGT_EXT_BUS;
			cs_num    = 3'((cpu_req.addr - `INT_REGION_TOP) >> BANK_SHIFT);
			ext_legal = remap_ff && bank_defined[cs_num]
				&& ((cpu_req.addr - `INT_REGION_TOP) >> BANK_SHIFT) < NUM_BANKS;
		end else if (cpu_req.addr >= `EXT_SRAM_BASE
			&& cpu_req.addr < `EXT_SRAM_BASE + `EXT_SRAM_BYTES) begin
			target     = TGT_EXT_SRAM;
			local_addr = cpu_req.addr - `EXT_SRAM_BASE;
		end else if (cpu_req.addr < `EXT_SRAM_BASE) begin
			if (remap_ff) begin
				target = TGT_PRIMARY_SRAM;
			end else if (boot_sel_ff) begin
				target = TGT_EXT_SRAM;
			end else begin
				target    = TGT_EXT_BUS;
				cs_num    = 3'h0;
				ext_legal = 1'b1;
			end
		end
	end

	// internal SRAM: single-cycle read and byte-lane write
	always_ff @(posedge clk) begin
		if (cpu_req.valid && fetch_en_ff) begin
			if (target == TGT_PRIMARY_SRAM) begin
				if (cpu_req.write) begin
					pri_mem[local_addr[12:2]] <= merge(pri_mem[local_addr[12:2]],
						cpu_req.wdata, lane_mask(cpu_req.size, local_addr[1:0]));
				end
			end else if (target == TGT_EXT_SRAM) begin
				if (cpu_req.write) begin
					ext_mem[local_addr[16:2]] <= merge(ext_mem[local_addr[16:2]],
						cpu_req.wdata, lane_mask(cpu_req.size, local_addr[1:0]));
				end
			end
		end
	end

	// read data capture
	always_ff @(posedge clk) begin
		case (target)
			TGT_PRIMARY_SRAM: rdata_ff <= pri_mem[local_addr[12:2]];
			TGT_EXT_SRAM:     rdata_ff <= ext_mem[local_addr[16:2]];
			TGT_PERIPH:       rdata_ff <= periph_rdata;
			default:          rdata_ff <= ext_rdata;
		endcase
	end

	// extended SRAM write detection, sticky until external reset; watchdog reset leaves it set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_detect_ff <= 1'b0;
		end else if (cpu_req.valid && cpu_req.write && target == TGT_EXT_SRAM) begin
			wr_detect_ff <= 1'b1;
		end
	end

	// external bus request with bank timing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_req_ff  <= '0;
			ext_busy_ff <= 1'b0;
		end else if (ext_busy_ff) begin
			if (ext_done) begin
				ext_busy_ff      <= 1'b0;
				ext_req_ff.valid <= 1'b0;
			end
		end else if (cpu_req.valid && fetch_en_ff && target == TGT_EXT_BUS && ext_legal) begin
			ext_busy_ff             <= 1'b1;
			ext_req_ff.valid        <= 1'b1;
			ext_req_ff.write        <= cpu_req.write;
			ext_req_ff.size         <= cpu_req.size;
			ext_req_ff.chip_sel     <= cs_num;
			ext_req_ff.wait_states  <= bank_cfg[cs_num].wait_states;
			ext_req_ff.float_cycles <= bank_cfg[cs_num].float_cycles;
			ext_req_ff.width16      <= remap_ff ? bank_cfg[cs_num].width16 : 1'b1;
			ext_req_ff.addr         <= cpu_req.addr;
			ext_req_ff.wdata        <= cpu_req.wdata;
		end
	end

	// abort only for external-region accesses before remap or to undefined banks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			abort_ff <= 1'b0;
		end else begin
			abort_ff <= cpu_req.valid && fetch_en_ff
				&& target == TGT_EXT_BUS && !ext_legal;
		end
	end

	// peripheral path: word access only, window decode
	always_comb begin
		periph_sel   = cpu_req.valid && fetch_en_ff && target == TGT_PERIPH;
		periph_write = cpu_req.write;
		periph_addr  = {cpu_req.addr[31:2], 2'b00};
		periph_wdata = cpu_req.wdata;
		periph_index = 8'(cpu_req.addr[21:0] >> `PERIPH_WIN_SHIFT);
		intc_sel     = periph_sel && cpu_req.addr >= `INTC_WINDOW_BASE;
	end

	// core-side answer
	always_comb begin
		cpu_rdata = rdata_ff;
		cpu_abort = abort_ff;
		cpu_ready = fetch_en_ff && !(ext_busy_ff && !ext_done);
	end

	assign ext_req            = ext_req_ff;
	assign fetch_enable       = fetch_en_ff;
	assign boot_from_ext_sram = boot_sel_ff;
	assign remapped           = remap_ff;
	assign ext_sram_wr_detect = wr_detect_ff;
	assign strap_free         = fetch_en_ff;

endmodule : system_address_decoder_remap

// ### verif/ext_bus_model.sv
// Purpose: behavioural external bus unit answering the decoder's requests
// Assumes: one request at a time, held until done
// Notes:   read data inverts whenever no request is pending; held while wait states count
`timescale 1ns/1ns
module ext_bus_model
	import addr_decoder_pkg::*;
(
	input  wire logic     clk,       // master clock
	input  wire logic     rst,       // external reset, high
	input  wire ext_req_s ext_req,   // request from the decoder
	output logic          ext_done,  // one-cycle completion
	output logic [31:0]   ext_rdata  // read data with done
);
	logic [3:0] cnt_ff;

	// count the bank's wait states, then answer for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff    <= 4'h0;
			ext_done  <= 1'b0;
			ext_rdata <= 32'h0;
		end else if (ext_req.valid && !ext_done) begin
			if (cnt_ff >= ext_req.wait_states) begin
				cnt_ff    <= 4'h0;
				ext_done  <= 1'b1;
				ext_rdata <= {ext_req.addr[15:0], ext_req.addr[15:0]};
			end else begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end else begin
			ext_done  <= 1'b0;
			ext_rdata <= ~ext_rdata; // released bus, no stale value
		end
	end
endmodule : ext_bus_model

// ### verif/system_address_decoder_remap_checker.sv
// Purpose: port-level assertions for the address decoder
// Assumes: single clock domain, rst asynchronous high
// Notes:   bound to every decoder instance
`timescale 1ns/1ns
module system_address_decoder_remap_checker
	import addr_decoder_pkg::*;
(
	input wire logic        clk,                // master clock
	input wire logic        rst,                // external reset
	input wire logic        wdog_reset,         // watchdog reset
	input wire cpu_req_s    cpu_req,            // core request
	input wire logic        cpu_abort,          // abort out
	input wire logic        fetch_enable,       // fetch allowed
	input wire logic        remap_command_bit,  // remap write
	input wire logic        periph_sel,         // peripheral select
	input wire logic [31:0] periph_addr,        // peripheral address
	input wire logic        intc_sel,           // interrupt window
	input wire logic        boot_from_ext_sram, // boot mode
	input wire logic        remapped,           // remap state
	input wire logic        ext_sram_wr_detect  // write detect
);
	localparam int FETCH_WAIT = 80;
	logic [7:0] cyc_ff;

	// edges since reset or watchdog release, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cyc_ff <= 8'h00;
		else if (wdog_reset)
			cyc_ff <= 8'h00;
		else if (cyc_ff != 8'hff)
			cyc_ff <= cyc_ff + 8'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_fetch; fetch_enable == (cyc_ff >= FETCH_WAIT); endproperty
	a_fetch: assert property (p_fetch) else $error("fetch enable timing wrong");
	property p_abort_src;
		cpu_abort |-> $past(cpu_req.valid) && $past(cpu_req.addr) >= 32'h0040_0000
			&& $past(cpu_req.addr) < 32'hffc0_0000;
	endproperty
	a_abort_src: assert property (p_abort_src) else $error("abort outside ext region");
	property p_periph_addr;
		cpu_req.valid && fetch_enable && cpu_req.addr >= 32'hffc0_0000
			|-> periph_sel && periph_addr == {cpu_req.addr[31:2], 2'b00};
	endproperty
	a_periph_addr: assert property (p_periph_addr) else $error("periph word access wrong");
	property p_intc; periph_sel |-> intc_sel == (cpu_req.addr[31:12] == 20'hfffff); endproperty
	a_intc: assert property (p_intc) else $error("intc window wrong");
	property p_remap_set; remap_command_bit && !wdog_reset |=> remapped; endproperty
	a_remap_set: assert property (p_remap_set) else $error("remap not taken");
	property p_remap_keep;
		remapped && !wdog_reset |=> remapped;
	endproperty
	a_remap_keep: assert property (p_remap_keep) else $error("remap undone");
	property p_boot_hold; !$past(rst) && !$past(rst, 2) |-> $stable(boot_from_ext_sram); endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("boot mode changed");
	property p_wr_detect;
		cpu_req.valid && cpu_req.write && fetch_enable && cpu_req.addr >= 32'h0010_0000
			&& cpu_req.addr < 32'h0012_0000 |=> ext_sram_wr_detect [*2];
	endproperty
	a_wr_detect: assert property (p_wr_detect) else $error("ext sram write missed");
	property p_early_cs;
		cpu_req.valid && fetch_enable && !remapped && cpu_req.addr >= 32'h0050_0000
			&& cpu_req.addr < 32'hffc0_0000 |=> cpu_abort;
	endproperty
	a_early_cs: assert property (p_early_cs) else $error("early chip select not refused");
endmodule : system_address_decoder_remap_checker

bind system_address_decoder_remap system_address_decoder_remap_checker i_chk (.*);

// ### verif/tb_top.sv
// Purpose: self-checking bench for the address decoder
// Assumes: design defaults, 8 banks of 1 MB
// Notes:   read data checked from a queue one cycle later
`timescale 1ns/1ns
module tb_top
	import addr_decoder_pkg::*;
;
	logic            clk, rst, wdog_reset, boot_select_pin, remap_command_bit, ext_done;
	logic            cpu_ready, cpu_abort, fetch_enable, periph_sel, periph_write, intc_sel;
	logic            boot_from_ext_sram, remapped, ext_sram_wr_detect, strap_free, want_rd, rd_d;
	logic [7:0]      bank_defined, periph_index;
	logic [31:0]     cpu_rdata, ext_rdata, periph_addr, periph_wdata, periph_rdata, rv;
	cpu_req_s        cpu_req;
	ext_req_s        ext_req, xr;
	bank_cfg_s [7:0] bank_cfg;
	logic [31:0]     q_exp[$];
	int              n_mismatch, num_checks, seed, n;

	system_address_decoder_remap i_system_address_decoder_remap (.*);
	ext_bus_model i_ext_bus_model (.*);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// read results stand from the edge after the access; sampled mid-cycle
	always @(negedge clk) begin
		if (rd_d && q_exp.size() == 0)
			chk("queue", 0, 1);
		else if (rd_d)
			chk("cpu_rdata", q_exp.pop_front(), cpu_rdata);
		rd_d <= want_rd;
	end

	task automatic wait_fetch;
		n = 0;
		while (fetch_enable !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("fetch_delay", 80, n);
		if (n >= 200)
			tally_and_finish();
	endtask : wait_fetch

	// one core access, external ones waited out
	task automatic acc(input logic wr, input acc_size_e sz, input logic [31:0] a, d, e,
			input logic rd, ab);
		@(posedge clk);
		#1;
		cpu_req = '{1'b1, wr, 1'b0, sz, a, d};
		want_rd = rd;
		if (rd)
			q_exp.push_back(e);
		#2;
		if (a >= 32'hffc0_0000) begin
			chk("periph_addr", {a[31:2], 2'b00}, periph_addr);
			chk("intc_sel", 32'(a[31:12] == 20'hfffff), 32'(intc_sel));
			chk("periph_index", 32'(a[21:14]), 32'(periph_index));
			chk("periph_wdata", d, periph_wdata);
			chk("periph_write", 32'(wr), 32'(periph_write));
		end
		@(posedge clk);
		#1;
		cpu_req.valid = 1'b0;
		want_rd = 1'b0;
		xr = ext_req;
		chk("cpu_abort", 32'(ab), 32'(cpu_abort));
		for (int k = 0; k < 40 && cpu_ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk("cpu_ready", 1, 32'(cpu_ready));
		if (cpu_ready !== 1'b1)
			tally_and_finish();
	endtask : acc

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1;
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask : pulse

	initial begin
		seed = 32;
		{rst, wdog_reset, boot_select_pin, remap_command_bit, want_rd} = 5'h10;
		cpu_req = '0;
		periph_rdata = 32'h0;
		bank_cfg = '0;
		bank_cfg[0].width16 = 1'b1;
		bank_cfg[1].wait_states = 4'h7;
		bank_cfg[1].float_cycles = 3'h5;
		bank_defined = 8'h03;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		wait_fetch();
		chk("boot", 0, 32'(boot_from_ext_sram));
		chk("strap_free", 1, 32'(strap_free));
		boot_select_pin = 1'b1;
		acc(0, SIZE_WORD, 32'h10, 0, 0, 0, 0);
		chk("ext_cs0", 5'h11, {xr.valid, xr.chip_sel, xr.width16});
		acc(0, SIZE_WORD, 32'h0050_0000, 0, 0, 0, 1);
		pulse(remap_command_bit);
		chk("remapped", 1, 32'(remapped));
		chk("boot_kept", 0, 32'(boot_from_ext_sram));
		acc(1, SIZE_WORD, 32'h0, 32'h1122_3344, 0, 0, 0);
		acc(1, SIZE_BYTE, 32'h1, 32'h0000_aa00, 0, 0, 0);
		acc(0, SIZE_WORD, 32'h0, 0, 32'h1122_aa44, 1, 0);
		rv = $random(seed);
		acc(1, SIZE_WORD, 32'h1c, rv, 0, 0, 0);
		acc(0, SIZE_WORD, 32'h1c, 0, rv, 1, 0);
		acc(0, SIZE_WORD, 32'h0050_0004, 0, 0, 0, 0);
		chk("ext_cs1", 8'h97, {xr.valid, xr.chip_sel, xr.wait_states});
		chk("ext_addr", 32'h0050_0004, xr.addr);
		chk("ext_float_width", 4'ha, {xr.float_cycles, xr.width16});
		acc(0, SIZE_WORD, 32'h00b0_0000, 0, 0, 0, 1);
		acc(0, SIZE_WORD, 32'h0030_0000, 0, 0, 0, 0);
		for (n = 0; n < 5; n++) begin
			rv = $random(seed);
			periph_rdata = $random(seed);
			if (n == 4)
				rv[21:12] = 10'h3ff;
			acc(n[1], n[0] ? SIZE_HALF : SIZE_BYTE, {10'h3ff, rv[21:0]}, rv, periph_rdata,
				!n[1], 0);
		end
		chk("wr_detect", 0, 32'(ext_sram_wr_detect));
		acc(1, SIZE_HALF, 32'h0010_0002, 32'hbeef_0000, 0, 0, 0);
		chk("wr_detect", 1, 32'(ext_sram_wr_detect));
		acc(1, SIZE_HALF, 32'h0010_0000, 32'h0000_cafe, 0, 0, 0);
		acc(0, SIZE_WORD, 32'h0010_0000, 0, 32'hbeef_cafe, 1, 0);
		pulse(wdog_reset);
		chk("remap_cleared", 0, 32'(remapped));
		chk("boot_after_wdog", 0, 32'(boot_from_ext_sram));
		wait_fetch();
		rst = 1'b1;
		repeat (12) @(posedge clk); // strap held stable
		#1;
		rst = 1'b0;
		wait_fetch();
		chk("boot_ext_sram", 1, 32'(boot_from_ext_sram));
		acc(1, SIZE_WORD, 32'h40, rv, 0, 0, 0);
		acc(0, SIZE_WORD, 32'h0010_0040, 0, rv, 1, 0);
		repeat (3) @(posedge clk);
		chk("queue_left", 0, q_exp.size());
		tally_and_finish();
	end
endmodule : tb_top
